/* File: rtl/ddp_pkg.sv */
package ddp_pkg;

   // Special-function addresses seen by this block
   localparam logic [7:0] ADDR_PTR_LOW = 8'h82;
   localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
   localparam logic [7:0] ADDR_CONTROL = 8'h85;
   localparam logic [7:0] ADDR_MODE = 8'h86;

   // Control register layout
   localparam int CTRL_SELECT_BIT = 0;
   localparam int CTRL_TOGGLE_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Mode register layout
   localparam int MODE_ZERO_LSB = 0;
   localparam int MODE_ONE_LSB = 2;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [15:0] POINTER_RESET = 16'h0000;

   // Step mode encodings
   localparam logic [1:0] STEP_NONE = 2'h0;
   localparam logic [1:0] STEP_RSVD = 2'h1;
   localparam logic [1:0] STEP_INC = 2'h2;
   localparam logic [1:0] STEP_DEC = 2'h3;

   // Pointer use requests from the core's execution logic
   typedef enum logic [2:0] {
      DDP_USE_NONE,
      DDP_USE_XREAD,
      DDP_USE_XWRITE,
      DDP_USE_LOAD,
      DDP_USE_CODE,
      DDP_USE_JUMP
   } ddp_use_t;

   // Special-function register access from the core
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ddp_sfr_req_t;

   // Pointer operation request; done marks the completion of a pointer use
   typedef struct packed {
      ddp_use_t use_kind;
      logic done;
      logic [15:0] imm;
      logic [7:0] acc;
   } ddp_op_req_t;

endpackage

/* File: rtl/ddp_step.sv */
`timescale 1ns/10ps
// Applies a step mode to one pointer value
module ddp_step (
   input wire logic [15:0] value,
   input wire logic [1:0] mode,
   output logic [15:0] result
);

   // Wraps modulo 65536; reserved code leaves the pointer alone
   always_comb begin
      case (mode)
         ddp_pkg::STEP_INC: result = value + 16'h0001;
         ddp_pkg::STEP_DEC: result = value - 16'h0001;
         ddp_pkg::STEP_NONE: result = value;
         ddp_pkg::STEP_RSVD: result = value;
         default: result = value;
      endcase
   end

endmodule

/* File: rtl/ddp_unit.sv */
`timescale 1ns/10ps
module ddp_unit (
   input wire logic clock,
   input wire logic rst,
   input wire ddp_pkg::ddp_sfr_req_t sfr_req,
   input wire ddp_pkg::ddp_op_req_t op_req,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   output logic [15:0] active_pointer,
   output logic [15:0] address_out,
   output logic address_valid,
   output logic pointer_select
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [15:0] pointer_zero_reg, pointer_zero_next;
   logic [15:0] pointer_one_reg, pointer_one_next;
   logic [7:0] pointer_control_reg, pointer_control_next;
   logic [7:0] pointer_mode_reg, pointer_mode_next;
   logic [7:0] rdata_reg, rdata_next;
   logic hit_reg, hit_next;
   logic [15:0] addr_reg, addr_next;
   logic addr_valid_reg, addr_valid_next;
   logic [15:0] stepped;
   logic [15:0] active_reg, active_next;

   logic sel;
   logic toggle_en;
   logic [15:0] cur_ptr;
   logic [1:0] cur_mode;
   logic ext_move_done;
   logic load_done;
   logic ctrl_wr;
   logic mode_wr;
   logic ptr_wr;

   // Register write decode, shared by every group that firmware can write
   function automatic logic sfr_write_to(input ddp_pkg::ddp_sfr_req_t q, input logic [7:0] a);
      return q.wr && (q.addr == a);
   endfunction

   // Decoded controls
   assign sel = pointer_control_reg[ddp_pkg::CTRL_SELECT_BIT];
   assign toggle_en = pointer_control_reg[ddp_pkg::CTRL_TOGGLE_BIT];
   assign cur_ptr = sel ? pointer_one_reg : pointer_zero_reg;
   assign cur_mode = sel ? pointer_mode_reg[ddp_pkg::MODE_ONE_LSB +: 2]
                         : pointer_mode_reg[ddp_pkg::MODE_ZERO_LSB +: 2];
   assign ext_move_done = op_req.done &&
                          (op_req.use_kind == ddp_pkg::DDP_USE_XREAD ||
                           op_req.use_kind == ddp_pkg::DDP_USE_XWRITE);
   assign load_done = op_req.done && op_req.use_kind == ddp_pkg::DDP_USE_LOAD;
   assign ctrl_wr = sfr_write_to(sfr_req, ddp_pkg::ADDR_CONTROL);
   assign mode_wr = sfr_write_to(sfr_req, ddp_pkg::ADDR_MODE);
   // Either byte lane of the active pointer
   assign ptr_wr = sfr_write_to(sfr_req, ddp_pkg::ADDR_PTR_LOW) ||
                   sfr_write_to(sfr_req, ddp_pkg::ADDR_PTR_HIGH);

   ddp_step u_step (
      .value(cur_ptr),
      .mode(cur_mode),
      .result(stepped)
   );

   // Write a byte lane into the currently active pointer
   function automatic logic [15:0] put_byte(input logic [15:0] p, input logic hi, input logic [7:0] b);
      logic [15:0] r;
      r = p;
      if (hi) begin
         r[15:8] = b;
      end else begin
         r[7:0] = b;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pointer group; firmware byte writes land in the active pointer only,
   // the background one is never touched
   always_comb begin
      logic [15:0] act;
      act = cur_ptr;
      if (ptr_wr) begin
         act = put_byte(act, sfr_req.addr == ddp_pkg::ADDR_PTR_HIGH, sfr_req.wdata);
      end
      if (load_done) begin
         act = op_req.imm;
      end
      // A finished external move wins over a byte write or load in the same cycle
      if (ext_move_done) begin
         act = stepped;
      end
      pointer_zero_next = sel ? pointer_zero_reg : act;
      pointer_one_next = sel ? act : pointer_one_reg;
      // Registered copy of whichever pointer the next selection exposes, so the
      // output never ripples through the select mux
      active_next = pointer_control_next[ddp_pkg::CTRL_SELECT_BIT] ? pointer_one_next
                                                                   : pointer_zero_next;
   end

   // Control group; the step above uses the old selection and the toggle here
   // only takes hold at the edge, so stepping always comes first
   always_comb begin
      pointer_control_next = pointer_control_reg;
      pointer_mode_next = pointer_mode_reg;
      if (ext_move_done && toggle_en) begin
         pointer_control_next[ddp_pkg::CTRL_SELECT_BIT] = ~sel;
      end
      // A firmware write takes priority and governs the next pointer use;
      // reserved bits are not stored, so they always read back as zero
      if (ctrl_wr) begin
         pointer_control_next = 8'h00;
         pointer_control_next[ddp_pkg::CTRL_SELECT_BIT] = sfr_req.wdata[ddp_pkg::CTRL_SELECT_BIT];
         pointer_control_next[ddp_pkg::CTRL_TOGGLE_BIT] = sfr_req.wdata[ddp_pkg::CTRL_TOGGLE_BIT];
      end
      if (mode_wr) begin
         pointer_mode_next = {4'h0, sfr_req.wdata[3:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read answer; unmapped addresses answer with no hit and a zero byte
   always_comb begin
      rdata_next = 8'h00;
      hit_next = 1'b0;
      if (sfr_req.rd) begin
         hit_next = 1'b1;
         case (sfr_req.addr)
            ddp_pkg::ADDR_PTR_LOW: rdata_next = cur_ptr[7:0];
            ddp_pkg::ADDR_PTR_HIGH: rdata_next = cur_ptr[15:8];
            ddp_pkg::ADDR_CONTROL: rdata_next = pointer_control_reg;
            ddp_pkg::ADDR_MODE: rdata_next = pointer_mode_reg;
            default: hit_next = 1'b0;
         endcase
      end
   end

   // Address generation; a held use shows its address on every cycle it
   // stands, always from the pointer as it was before any step
   always_comb begin
      addr_next = addr_reg;
      addr_valid_next = 1'b0;
      case (op_req.use_kind)
         ddp_pkg::DDP_USE_XREAD, ddp_pkg::DDP_USE_XWRITE: begin
            addr_next = cur_ptr;
            addr_valid_next = 1'b1;
         end
         ddp_pkg::DDP_USE_CODE, ddp_pkg::DDP_USE_JUMP: begin
            addr_next = cur_ptr + {8'h00, op_req.acc};
            addr_valid_next = 1'b1;
         end
         default: addr_valid_next = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pointer registers
   always_ff @(posedge clock) begin
      if (rst) begin
         pointer_zero_reg <= ddp_pkg::POINTER_RESET;
         pointer_one_reg <= ddp_pkg::POINTER_RESET;
         active_reg <= ddp_pkg::POINTER_RESET;
      end else begin
         pointer_zero_reg <= pointer_zero_next;
         pointer_one_reg <= pointer_one_next;
         active_reg <= active_next;
      end
   end

   // Control registers; reset leaves pointer zero active
   always_ff @(posedge clock) begin
      if (rst) begin
         pointer_control_reg <= ddp_pkg::CTRL_RESET;
         pointer_mode_reg <= ddp_pkg::MODE_RESET;
      end else begin
         pointer_control_reg <= pointer_control_next;
         pointer_mode_reg <= pointer_mode_next;
      end
   end

   // Read answer registers; the answer stands for one cycle only
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_reg <= 8'h00;
         hit_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         hit_reg <= hit_next;
      end
   end

   // Address registers; the last address is held while idle
   always_ff @(posedge clock) begin
      if (rst) begin
         addr_reg <= 16'h0000;
         addr_valid_reg <= 1'b0;
      end else begin
         addr_reg <= addr_next;
         addr_valid_reg <= addr_valid_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops
   assign sfr_rdata = rdata_reg;
   assign sfr_hit = hit_reg;
   assign address_out = addr_reg;
   assign address_valid = addr_valid_reg;
   assign pointer_select = pointer_control_reg[ddp_pkg::CTRL_SELECT_BIT];
   assign active_pointer = active_reg;

endmodule

/* File: tb/ddp_unit_asserts.sv */
`timescale 1ns/10ps
// Port checks; one clock domain, so shared clocking
module ddp_unit_asserts (
   input wire logic clock,
   input wire logic rst,
   input wire ddp_pkg::ddp_sfr_req_t sfr_req,
   input wire ddp_pkg::ddp_op_req_t op_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_hit,
   input wire logic [15:0] active_pointer,
   input wire logic [15:0] address_out,
   input wire logic address_valid,
   input wire logic pointer_select
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   logic xm;
   logic cj;
   // Only external moves may change the selection on their own
   assign xm = op_req.use_kind inside {ddp_pkg::DDP_USE_XREAD, ddp_pkg::DDP_USE_XWRITE};
   assign cj = op_req.use_kind inside {ddp_pkg::DDP_USE_CODE, ddp_pkg::DDP_USE_JUMP};
   a_sel_after_reset: assert property ($past(rst) |-> !pointer_select) else $error("select set");
   a_ctrl_write_sel: assert property (sfr_req.wr && sfr_req.addr == 8'h85
      |=> pointer_select == $past(sfr_req.wdata[0])) else $error("select write lost");
   a_sel_hold: assert property (!(op_req.done && xm) && !(sfr_req.wr && sfr_req.addr == 8'h85)
      |=> $stable(pointer_select)) else $error("select moved");
   a_ctrl_read_bits: assert property (sfr_req.rd && sfr_req.addr == 8'h85
      |=> sfr_hit && sfr_rdata[0] == $past(pointer_select) && sfr_rdata[7] == 1'b0 && sfr_rdata[5:1] == 5'h00)
      else $error("control read");
   a_unmapped_miss: assert property (sfr_req.rd && sfr_req.addr[7:4] != 4'h8
      |=> !sfr_hit && sfr_rdata == 8'h00) else $error("unmapped hit");
   a_move_address: assert property (xm |=> address_valid && address_out == $past(active_pointer))
      else $error("move address");
   a_code_jump_sum: assert property (cj |=> address_valid
      && address_out == 16'($past(active_pointer) + $past(op_req.acc))) else $error("indexed address");
   a_load_active: assert property (op_req.done && op_req.use_kind == ddp_pkg::DDP_USE_LOAD && !sfr_req.wr
      |=> active_pointer == $past(op_req.imm)) else $error("load lost");
   a_idle_no_address: assert property (!xm && !cj |=> !address_valid) else $error("stray address");
endmodule
bind ddp_unit ddp_unit_asserts ddp_unit_asserts_i (.clock(clock), .rst(rst), .sfr_req(sfr_req), .op_req(op_req),
   .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .active_pointer(active_pointer), .address_out(address_out),
   .address_valid(address_valid), .pointer_select(pointer_select));

/* File: tb/ddp_core_model.sv */
`timescale 1ns/10ps
// Core side: one pointer use, done at once or after a wait cycle
module ddp_core_model (
   input wire logic clock,
   output ddp_pkg::ddp_op_req_t op_req
);
   initial op_req = '0;
   task automatic run(input ddp_pkg::ddp_use_t k, input logic [15:0] i, input logic [7:0] a, input bit slow);
      op_req = {k, !slow, i, a};
      @(negedge clock);
      if (slow) begin
         op_req.done = 1'b1;
         @(negedge clock);
      end
      // Stale operands are inverted so nobody can lean on them
      op_req = {ddp_pkg::DDP_USE_NONE, 1'b0, ~i, ~a};
      // One idle cycle, so the next request never lands in the release step
      @(negedge clock);
   endtask
endmodule

/* File: tb/dual_data_pointer_unit_tb.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; $display("BAD %0t %h %h", $time, a, e); end end
module dual_data_pointer_unit_tb;
   logic clock = 0;
   logic rst = 1;
   ddp_pkg::ddp_sfr_req_t sfr_req = '0;
   ddp_pkg::ddp_op_req_t op_req;
   logic [7:0] sfr_rdata;
   logic sfr_hit, address_valid, pointer_select, rd_d;
   logic [15:0] active_pointer, address_out, r, ea;
   logic [8:0] er;
   logic [15:0] p[2] = '{16'h0000, 16'h0000};
   logic [7:0] ra[6] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h90};
   logic sel = 0;
   logic tog = 0;
   logic [3:0] md = 4'h0;
   logic [31:0] seed = 29;
   logic [15:0] aq[$];
   logic [8:0] rq[$];
   int errors = 0;
   int checked = 0;
   int cyc = 0;
   ddp_unit ddp_unit_i (.clock(clock), .rst(rst), .sfr_req(sfr_req), .op_req(op_req), .sfr_rdata(sfr_rdata),
      .sfr_hit(sfr_hit), .active_pointer(active_pointer), .address_out(address_out),
      .address_valid(address_valid), .pointer_select(pointer_select));
   ddp_core_model ddp_core_model_i (.clock(clock), .op_req(op_req));
   initial forever #5 clock = ~clock;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic finish_test();
      // Notes that no result ever matched count as a mismatch too
      if (aq.size() != 0 || rq.size() != 0) errors++;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Register access; the note of a read is its hit flag and byte
   task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      case (a)
         8'h82: v = p[sel][7:0];
         8'h83: v = p[sel][15:8];
         8'h85: v = {1'b0, tog, 5'h00, sel};
         8'h86: v = {4'h0, md};
         default: v = 8'h00;
      endcase
      if (!w) rq.push_back({a inside {8'h82, 8'h83, 8'h85, 8'h86}, v});
      else if (a == 8'h85) {tog, sel} = {d[6], d[0]};
      else if (a == 8'h86) md = d[3:0];
      else if (a == 8'h82) p[sel][7:0] = d;
      else if (a == 8'h83) p[sel][15:8] = d;
      sfr_req = {w, !w, a, d};
      @(negedge clock);
      sfr_req = {2'b00, ~a, ~d};
      // One idle cycle, so the next strobe never lands in the release step
      @(negedge clock);
   endtask
   // Pointer use: an address note per presented cycle, then step before toggle
   task automatic op(input ddp_pkg::ddp_use_t k, input logic [15:0] i, input logic [7:0] a, input bit slow);
      logic [1:0] m;
      bit xm;
      m = md[2 * sel +: 2];
      xm = k inside {ddp_pkg::DDP_USE_XREAD, ddp_pkg::DDP_USE_XWRITE};
      repeat (slow ? 2 : 1) begin
         if (xm) aq.push_back(p[sel]);
         if (k inside {ddp_pkg::DDP_USE_CODE, ddp_pkg::DDP_USE_JUMP}) aq.push_back(p[sel] + a);
      end
      if (k == ddp_pkg::DDP_USE_LOAD) p[sel] = i;
      if (xm && m == 2'h2) p[sel]++;
      if (xm && m == 2'h3) p[sel]--;
      if (xm) sel ^= tog;
      ddp_core_model_i.run(k, i, a, slow);
      `CHK({pointer_select, active_pointer}, {sel, p[sel]})
   endtask
   // Read strobe history and the hang limit
   always @(posedge clock) begin
      rd_d <= sfr_req.rd;
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         errors++;
         finish_test();
      end
   end
   // Results are matched oldest note first; a result with no note left fails
   always @(negedge clock) begin
      if (address_valid === 1'b1) begin
         ea = (aq.size() > 0) ? aq.pop_front() : 'x;
         `CHK(address_out, ea)
      end
      if (rd_d === 1'b1) begin
         er = (rq.size() > 0) ? rq.pop_front() : 'x;
         `CHK({sfr_hit, sfr_rdata}, er)
      end
   end
   initial begin
      repeat (2) @(negedge clock);
      rst = 0;
      foreach (ra[j]) sfr(0, ra[j], 8'h00);
      $display("reset values done");
      op(ddp_pkg::DDP_USE_LOAD, 16'h1234, 8'h00, 0);
      sfr(1, 8'h85, 8'h01);
      sfr(1, 8'h82, 8'hCD);
      sfr(1, 8'h83, 8'hAB);
      op(ddp_pkg::DDP_USE_XREAD, 16'h0000, 8'h00, 0);
      sfr(1, 8'h85, 8'h00);
      foreach (ra[j]) sfr(0, ra[j], 8'h00);
      $display("selection done");
      // Every step code with toggling, starting at both wrap edges
      for (int s = 0; s < 4; s++) begin
         sfr(1, 8'h86, 8'(s * 5));
         op(ddp_pkg::DDP_USE_LOAD, 16'hFFFF, 8'h00, 0);
         sfr(1, 8'h85, 8'h41);
         op(ddp_pkg::DDP_USE_LOAD, 16'h0000, 8'h00, 1);
         sfr(1, 8'h85, 8'h40);
         repeat (3) op(ddp_pkg::DDP_USE_XREAD, 16'h0000, 8'h00, 0);
         op(ddp_pkg::DDP_USE_XWRITE, 16'h0000, 8'h00, 1);
         op(ddp_pkg::DDP_USE_CODE, 16'h0000, 8'hFF, 0);
         op(ddp_pkg::DDP_USE_JUMP, 16'h0000, 8'h80, 1);
         foreach (ra[j]) sfr(0, ra[j], 8'h00);
      end
      $display("step modes done");
      repeat (80) begin
         r = 16'(rnd());
         if (r[3:0] == 4'h0) sfr(1, 8'h85, r[15:8]);
         else if (r[3:0] == 4'h1) sfr(1, 8'h86, r[15:8]);
         else if (r[3:0] == 4'h2) sfr(0, {6'h20, r[9:8]}, 8'h00);
         else op(ddp_pkg::ddp_use_t'(3'(1 + r[7:4] % 5)), 16'(rnd()), r[15:8], r[9]);
      end
      $display("random mix done");
      repeat (3) @(negedge clock);
      finish_test();
   end
endmodule
